// ### common/emu_pkg.sv
// Shared constants and carriers for the emulator target control block.
// Assumes a single 50 MHz system clock; no register bus, options are ports.
package emu_pkg;
    // Data address space and mapping granularity
    localparam int          ADDR_W        = 16;
    localparam int          BLOCK_W       = 8;           // 256-byte blocks
    localparam int          NBLOCKS       = 256;         // 64K / 256
    localparam logic [7:0]  FIRST_BLOCK   = 8'h03;       // 0x300..0x3ff
    localparam logic [15:0] LAST_ADDR     = 16'hffff;

    // Pod clock divider: 50 MHz base, pod clock limits 8000 kHz .. 32 kHz, giving 6250 kHz .. 32 kHz
    localparam int          CLK_KHZ       = 50000;
    localparam int          POD_MAX_KHZ   = 8000;
    localparam int          POD_MIN_KHZ   = 32;
    localparam int          DIV_W         = 10;
    localparam logic [9:0]  DIV_MIN       = 10'((CLK_KHZ / 2 + POD_MAX_KHZ - 1) / POD_MAX_KHZ);
    localparam logic [9:0]  DIV_MAX       = 10'(CLK_KHZ / 2 / POD_MIN_KHZ);

    // Start-up counts in CPU clocks
    localparam logic [15:0] CNT_1K        = 16'h0400;
    localparam logic [15:0] CNT_6K        = 16'h1800;
    localparam logic [15:0] CNT_16K       = 16'h4000;
    localparam logic [15:0] CNT_32K       = 16'h8000;

    // Extra delays, in microseconds, and their cycle counts at 50 MHz
    localparam int          DLY_LONG_US   = 64000;
    localparam int          DLY_MED_US    = 4000;
    localparam int          DLY_LONG_CYC  = DLY_LONG_US * (CLK_KHZ / 1000);
    localparam int          DLY_MED_CYC   = DLY_MED_US * (CLK_KHZ / 1000);

    typedef enum logic [1:0] {DLY_NONE = 2'h0, DLY_MED = 2'h1, DLY_LONG = 2'h2} dly_t;

    // Host option set
    typedef struct packed {
        logic       mask_int_step;
        logic       step_timer;
        logic       ext_reset_en;
        logic       xram_en;
        logic       pod_clk_sel;
        logic [9:0] pod_div;
        logic [3:0] rst_mode;
    } opts_t;

    // Mapping range write
    typedef struct packed {
        logic        wr;
        logic        set;      // 1 maps to target, 0 back to pod
        logic [15:0] first;
        logic [15:0] last;
    } map_cmd_t;
endpackage

// ### core/pod_clk_gen.sv
// Pod clock generator: toggles a clock output at a programmable divide.
// Assumes divisor comes from the host option set; clamped to the legal range.
`timescale 1ns/100ps
module pod_clk_gen
    import emu_pkg::*;
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Divisor, half periods in system clocks
    input  wire logic [DIV_W-1:0] div,
    // Generated clock
    output logic                  pod_clk
);
    logic [DIV_W-1:0] cnt_r, cnt_nxt, lim;
    logic             clk_r, clk_nxt;

    // Clamp keeps frequency inside 32 kHz .. 8000 kHz
    always_comb begin
        lim = (div < DIV_MIN) ? DIV_MIN : ((div > DIV_MAX) ? DIV_MAX : div);
        cnt_nxt = cnt_r + 10'h001;
        clk_nxt = clk_r;
        if (cnt_r >= lim - 10'h001) begin
            cnt_nxt = 10'h000;
            clk_nxt = ~clk_r;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 10'h000;
            clk_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            clk_r <= clk_nxt;
        end
    end

    assign pod_clk = clk_r;
endmodule

// ### core/emulator_target_control.sv
// Emulator pod target control: data memory steering, step gating, reset
// gating, CPU clock selection and start-up delay.
// Assumes all inputs are synchronous to clock; target clock is sampled here.
// Summary of operation
// - Data accesses go to pod RAM unless their block is mapped to target.
// - Each 256-byte block holds its own target-or-pod selection bit.
// - Blocks below 0x300 are never sent to the target.
// - One range write maps every block it covers from 0x300 up to 0xffff.
// - Mask option blocks interrupt acceptance during single steps.
// - Step-timer option makes timers tick only while running or with stepped instructions.
// - Other peripherals keep running while execution is halted.
// - Target reset pin reaches CPU only when enabled and running user code.
// - External RAM write enable forced off for variants without the bus.
// - CPU clock is target clock or pod clock of 6250 to 32 kHz.
// - Sixteen delay modes combine long, medium or no delay with counts.
`timescale 1ns/100ps
module emulator_target_control
    import emu_pkg::*;
#(
    parameter int LONG_CYC = DLY_LONG_CYC,
    parameter int MED_CYC  = DLY_MED_CYC
)(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              nrst,
    // Host options and map commands
    input  wire opts_t             opts,
    input  wire map_cmd_t          map_cmd,
    input  wire logic              has_xbus,
    input  wire logic              host_reset,
    // CPU execution state
    input  wire logic              running,
    input  wire logic              stepping,
    input  wire logic              step_pulse,
    input  wire logic              irq_req,
    // CPU data access
    input  wire logic [ADDR_W-1:0] data_addr,
    input  wire logic              data_wr,
    // Target side
    input  wire logic              tgt_reset_n,
    input  wire logic              tgt_clk,
    // Outputs to CPU and memories
    output logic                   to_target,
    output logic                   pod_ram_we,
    output logic                   tgt_ram_we,
    output logic                   irq_accept,
    output logic                   timer_tick,
    output logic                   periph_run,
    output logic                   cpu_clk,
    output logic                   cpu_reset
);
    logic rst_s1_r, rst_n;

    // Reset release through two flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // Block index of an address
    function automatic logic [7:0] blk(input logic [15:0] a);
        return a[15:BLOCK_W];
    endfunction

    // Map table
    logic [NBLOCKS-1:0] map_r, map_nxt;
    logic [7:0]         b_lo, b_hi;

    always_comb begin
        map_nxt = map_r;
        b_lo = blk(map_cmd.first);
        b_hi = blk(map_cmd.last);
        if (map_cmd.wr) begin
            for (int i = 0; i < NBLOCKS; i++) begin
                // Whole range in one write; low blocks stay on pod
                if (8'(i) >= b_lo && 8'(i) <= b_hi && 8'(i) >= FIRST_BLOCK) begin
                    map_nxt[i] = map_cmd.set;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            map_r <= '0;
        end else begin
            map_r <= map_nxt;
        end
    end

    // Steering: pod RAM unless block mapped and at or above first valid block
    logic xram_ok;
    always_comb begin
        xram_ok   = opts.xram_en & has_xbus;
        to_target = map_r[blk(data_addr)] && (blk(data_addr) >= FIRST_BLOCK);
        pod_ram_we = xram_ok & data_wr & ~to_target;
        tgt_ram_we = xram_ok & data_wr & to_target;
    end

    // Step gating: interrupts, timers; other peripherals never stop
    always_comb begin
        irq_accept = irq_req & ~(stepping & opts.mask_int_step);
        if (opts.step_timer) begin
            timer_tick = running | (stepping & step_pulse);
        end else begin
            timer_tick = 1'b1;
        end
        periph_run = 1'b1;
    end

    // CPU clock source
    logic pod_clk;
    logic tclk_s1_r, tclk_r;

    pod_clk_gen u_clk (
        .clock   (clock),
        .rst_n   (rst_n),
        .div     (opts.pod_div),
        .pod_clk (pod_clk)
    );

    // Target clock synchroniser; only second flop is used
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tclk_s1_r <= 1'b0;
            tclk_r    <= 1'b0;
        end else begin
            tclk_s1_r <= tgt_clk;
            tclk_r    <= tclk_s1_r;
        end
    end

    logic clk_sel_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_sel_r <= 1'b0;
        end else begin
            clk_sel_r <= opts.pod_clk_sel ? pod_clk : tclk_r;
        end
    end
    assign cpu_clk = clk_sel_r;

    // CPU clock rising edge, used to count start-up clocks
    logic clk_prev_r, cpu_edge;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_r <= 1'b0;
        end else begin
            clk_prev_r <= clk_sel_r;
        end
    end
    assign cpu_edge = clk_sel_r & ~clk_prev_r;

    // Decode of mode into delay class and clock count
    function automatic dly_t mode_dly(input logic [3:0] m);
        unique case (m)
            4'h2, 4'h5, 4'h8, 4'h9, 4'ha, 4'hd: return DLY_LONG;
            4'h0, 4'h3, 4'h6, 4'hb, 4'he:       return DLY_MED;
            default:                            return DLY_NONE;
        endcase
    endfunction

    function automatic logic [15:0] mode_cnt(input logic [3:0] m);
        unique case (m)
            4'h8:               return CNT_32K;
            4'h9, 4'hd, 4'he, 4'hf: return CNT_1K;
            4'ha, 4'hb, 4'hc:   return CNT_16K;
            default:            return CNT_6K;
        endcase
    endfunction

    // Reset request: host always, target pin only when enabled and running
    logic rst_req;
    assign rst_req = host_reset | (opts.ext_reset_en & running & ~tgt_reset_n);

    // Start-up sequencer
    typedef enum logic [2:0] {
        S_HOLD  = 3'b001,
        S_DELAY = 3'b010,
        S_COUNT = 3'b100
    } st_t;

    st_t         st_r, st_nxt;
    logic [31:0] dcnt_r, dcnt_nxt;
    logic [15:0] ccnt_r, ccnt_nxt;

    always_comb begin
        st_nxt   = st_r;
        dcnt_nxt = dcnt_r;
        ccnt_nxt = ccnt_r;
        if (rst_req) begin
            st_nxt = S_HOLD;
        end else begin
            unique case (st_r)
                S_HOLD: begin
                    // Latch the selected mode at release
                    unique case (mode_dly(opts.rst_mode))
                        DLY_LONG: dcnt_nxt = 32'(LONG_CYC);
                        DLY_MED:  dcnt_nxt = 32'(MED_CYC);
                        default:  dcnt_nxt = 32'h0000_0000;
                    endcase
                    ccnt_nxt = mode_cnt(opts.rst_mode);
                    st_nxt   = S_DELAY;
                end
                S_DELAY: begin
                    if (dcnt_r == 32'h0000_0000) begin
                        st_nxt = S_COUNT;
                    end else begin
                        dcnt_nxt = dcnt_r - 32'h0000_0001;
                    end
                end
                S_COUNT: begin
                    if (ccnt_r != 16'h0000 && cpu_edge) begin
                        ccnt_nxt = ccnt_r - 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= S_HOLD;
            dcnt_r <= 32'h0000_0000;
            ccnt_r <= 16'h0000;
        end else begin
            st_r   <= st_nxt;
            dcnt_r <= dcnt_nxt;
            ccnt_r <= ccnt_nxt;
        end
    end

    // Held until delay and clock count both done
    logic cpu_reset_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_reset_r <= 1'b1;
        end else begin
            cpu_reset_r <= rst_req || st_nxt != S_COUNT || ccnt_nxt != 16'h0000;
        end
    end
    assign cpu_reset = cpu_reset_r;

    // Checks
    sequence s_release;
        st_r == S_HOLD && !rst_req;
    endsequence

    sequence s_count_done;
        st_r == S_COUNT && ccnt_r == 16'h0000;
    endsequence

    a_low_block_pod: assert property (@(posedge clock) disable iff (!rst_n)
        blk(data_addr) < FIRST_BLOCK |-> !to_target)
        else $error("low block steered to target");
    a_default_pod: assert property (@(posedge clock) disable iff (!rst_n)
        !map_r[blk(data_addr)] |-> !to_target)
        else $error("unmapped block steered to target");
    a_range_maps: assert property (@(posedge clock) disable iff (!rst_n)
        map_cmd.wr && map_cmd.set && blk(map_cmd.first) <= FIRST_BLOCK
        && blk(map_cmd.last) == 8'hff |=> &map_r[NBLOCKS-1:3])
        else $error("range did not map all blocks");
    a_map_clear: assert property (@(posedge clock) disable iff (!rst_n)
        map_cmd.wr && !map_cmd.set && blk(map_cmd.first) <= FIRST_BLOCK
        && blk(map_cmd.last) == 8'hff |=> map_r == '0)
        else $error("range did not return all blocks to pod");
    a_block_keep: assert property (@(posedge clock) disable iff (!rst_n)
        !map_cmd.wr |=> $stable(map_r))
        else $error("map changed without write");
    a_irq_mask: assert property (@(posedge clock) disable iff (!rst_n)
        stepping && opts.mask_int_step |-> !irq_accept)
        else $error("interrupt accepted in masked step");
    a_timer_hold: assert property (@(posedge clock) disable iff (!rst_n)
        opts.step_timer && !running && !step_pulse |-> !timer_tick)
        else $error("timer ticked while halted");
    a_step_tick: assert property (@(posedge clock) disable iff (!rst_n)
        opts.step_timer && stepping && step_pulse |-> timer_tick)
        else $error("timer missed a stepped instruction");
    a_periph_run: assert property (@(posedge clock) disable iff (!rst_n)
        periph_run)
        else $error("peripherals stopped");
    a_xram_gate: assert property (@(posedge clock) disable iff (!rst_n)
        !has_xbus |-> !pod_ram_we && !tgt_ram_we)
        else $error("external RAM write without bus");
    a_ext_reset: assert property (@(posedge clock) disable iff (!rst_n)
        opts.ext_reset_en && running && !tgt_reset_n |=> cpu_reset)
        else $error("target reset not forwarded");
    a_host_reset: assert property (@(posedge clock) disable iff (!rst_n)
        host_reset |=> cpu_reset)
        else $error("host reset not applied");
    // Clock mux is one flop deep, so the output lags its source by a cycle
    a_pod_clk_sel: assert property (@(posedge clock) disable iff (!rst_n)
        opts.pod_clk_sel |=> cpu_clk == $past(pod_clk))
        else $error("pod clock not selected");
    a_tgt_clk_sel: assert property (@(posedge clock) disable iff (!rst_n)
        !opts.pod_clk_sel |=> cpu_clk == $past(tclk_r))
        else $error("target clock not selected");
    a_reset_hold: assert property (@(posedge clock) disable iff (!rst_n)
        s_release ##1 1'b1 |-> cpu_reset [*2])
        else $error("CPU released too early");
    // Release only after the whole count; the delay alone is not enough
    a_count_wait: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(cpu_reset) |-> s_count_done)
        else $error("CPU released before count ended");
endmodule

// ### dv/target_board.sv
// Target board model: free-running target oscillator and its reset pin.
// Assumes the bench requests a board reset through pull_rst.
`timescale 1ns/100ps
module target_board #(
    parameter int HALF_NS = 50
)(
    // Bench control
    input  wire logic pull_rst,
    // Target pins
    output logic      tgt_clk,
    output logic      tgt_reset_n
);
    // Crystal runs whether or not the pod takes its clock
    initial begin
        tgt_clk = 1'b0;
        // Quarter-period offset keeps oscillator edges off the pod clock edges
        #(HALF_NS / 2);
        forever #(HALF_NS) tgt_clk = ~tgt_clk;
    end
    // Pin has a pull-up, so it idles high unless the board pulls it
    assign tgt_reset_n = ~pull_rst;
endmodule

// ### dv/emulator_target_control_test.sv
// Self-checking bench for the emulator target control block.
// Assumes 50 MHz clock and start-up delays shortened to 20 and 10 cycles.
`timescale 1ns/100ps
module emulator_target_control_test;
    import emu_pkg::*;
    localparam int         LONG     = 20;
    localparam int         MED      = 10;
    localparam logic [3:0] MODES[3] = '{4'hf, 4'he, 4'h9};
    localparam int         DLYS[3]  = '{0, MED, LONG};
    logic              clock, nrst, has_xbus, host_reset, running, stepping;
    logic              step_pulse, irq_req, data_wr, pull_rst, tgt_reset_n, tgt_clk;
    logic              to_target, pod_ram_we, tgt_ram_we, irq_accept, timer_tick;
    logic              periph_run, cpu_clk, cpu_reset;
    logic [ADDR_W-1:0] data_addr;
    opts_t             opts;
    map_cmd_t          map_cmd;
    int                error_cnt = 0;
    int                n_checks = 0;

    emulator_target_control #(.LONG_CYC(LONG), .MED_CYC(MED)) i_emulator_target_control (
        .clock(clock), .nrst(nrst), .opts(opts), .map_cmd(map_cmd), .has_xbus(has_xbus),
        .host_reset(host_reset), .running(running), .stepping(stepping),
        .step_pulse(step_pulse), .irq_req(irq_req), .data_addr(data_addr),
        .data_wr(data_wr), .tgt_reset_n(tgt_reset_n), .tgt_clk(tgt_clk),
        .to_target(to_target), .pod_ram_we(pod_ram_we), .tgt_ram_we(tgt_ram_we),
        .irq_accept(irq_accept), .timer_tick(timer_tick), .periph_run(periph_run),
        .cpu_clk(cpu_clk), .cpu_reset(cpu_reset));
    target_board i_target_board (.pull_rst(pull_rst), .tgt_clk(tgt_clk),
        .tgt_reset_n(tgt_reset_n));

    // 20 ns system clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask
    task automatic check_in(input string what, input int val, input int lo, input int hi);
        n_checks++;
        if (val < lo || val > hi) begin
            error_cnt++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, val);
        end
    endtask
    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Helpers: every input change lands just after a falling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Lets combinational outputs follow inputs changed at the falling edge
    task automatic settle;
        #1;
    endtask
    task automatic map(input logic set, input logic [15:0] first, input logic [15:0] last);
        @(negedge clock);
        map_cmd = '{wr: 1'b1, set: set, first: first, last: last};
        @(negedge clock);
        map_cmd.wr = 1'b0;
    endtask
    task automatic probe(input logic [15:0] addr, input logic exp);
        @(negedge clock);
        data_addr = addr;
        #1;
        check_bit("to_target", exp, to_target);
    endtask
    // Bounded wait, so a stuck reset ends as a mismatch rather than a hang
    task automatic wait_rel(output int n);
        n = 0;
        while (cpu_reset !== 1'b0 && n < 20000) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic count_edges(input int n, output int c);
        logic prev;
        c = 0;
        prev = cpu_clk;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (cpu_clk === 1'b1 && prev === 1'b0) c++;
            prev = cpu_clk;
        end
        @(negedge clock);
    endtask

    task automatic t_map;
        probe(16'h0700, 1'b0);
        map(1'b1, 16'h0700, 16'h07ff);
        map(1'b1, 16'h3000, 16'h30ff);
        probe(16'h0700, 1'b1);
        probe(16'h07ff, 1'b1);
        probe(16'h3080, 1'b1);
        probe(16'h0800, 1'b0);
        probe(16'h06ff, 1'b0);
        map(1'b1, 16'h0000, LAST_ADDR);
        probe(16'h02ff, 1'b0);
        probe(16'h0000, 1'b0);
        probe(16'h0300, 1'b1);
        probe(16'hffff, 1'b1);
        map(1'b0, 16'h0300, LAST_ADDR);
        probe(16'h8000, 1'b0);
        map(1'b1, 16'h0700, 16'h07ff);
        $display("test map done");
    endtask

    task automatic t_we;
        data_wr = 1'b1;
        probe(16'h0700, 1'b1);
        check_bit("tgt_ram_we", 1'b1, tgt_ram_we);
        check_bit("pod_ram_we", 1'b0, pod_ram_we);
        probe(16'h0800, 1'b0);
        check_bit("pod_ram_we", 1'b1, pod_ram_we);
        cyc(1);
        has_xbus = 1'b0;
        settle();
        check_bit("pod_ram_we", 1'b0, pod_ram_we);
        cyc(1);
        data_addr = 16'h0700;
        settle();
        check_bit("tgt_ram_we", 1'b0, tgt_ram_we);
        cyc(1);
        has_xbus = 1'b1;
        opts.xram_en = 1'b0;
        settle();
        check_bit("tgt_ram_we", 1'b0, tgt_ram_we);
        cyc(1);
        opts.xram_en = 1'b1;
        data_wr = 1'b0;
        $display("test write enable done");
    endtask

    // Every mask, step and request combination; halted means not running
    task automatic t_irq_timer;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            {opts.mask_int_step, stepping, irq_req} = 3'(i);
            running = ~stepping;
            settle();
            check_bit("irq_accept", irq_req & ~(opts.mask_int_step & stepping),
                      irq_accept);
        end
        for (int i = 0; i < 16; i++) begin
            cyc(1);
            {opts.step_timer, running, stepping, step_pulse} = 4'(i);
            settle();
            check_bit("timer_tick", ~opts.step_timer | running | (stepping & step_pulse),
                      timer_tick);
            check_bit("periph_run", 1'b1, periph_run);
        end
        cyc(1);
        {running, stepping, step_pulse} = 3'b100;
        $display("test step options done");
    endtask

    task automatic t_clock;
        int c;
        opts.pod_div = DIV_MIN;
        count_edges(800, c);
        check_in("pod clock edges", c, 99, 101);
        opts.pod_div = 10'h002;
        cyc(40);
        count_edges(800, c);
        check_in("clamped clock edges", c, 99, 101);
        opts.pod_div = 10'h00a;
        cyc(40);
        count_edges(800, c);
        check_in("slow clock edges", c, 39, 41);
        opts.pod_clk_sel = 1'b0;
        cyc(20);
        count_edges(800, c);
        check_in("target clock edges", c, 158, 162);
        opts.pod_clk_sel = 1'b1;
        opts.pod_div = DIV_MIN;
        cyc(40);
        $display("test clock done");
    endtask

    task automatic t_reset;
        int n;
        for (int i = 0; i < 3; i++) begin
            opts.rst_mode = MODES[i];
            host_reset = 1'b1;
            cyc(3);
            check_bit("cpu_reset", 1'b1, cpu_reset);
            host_reset = 1'b0;
            wait_rel(n);
            check_in("reset cycles", n, DLYS[i] + 8176, DLYS[i] + 8232);
        end
        // A 6K count must still hold the CPU well past any 1K release
        opts.rst_mode = 4'h4;
        host_reset = 1'b1;
        cyc(3);
        host_reset = 1'b0;
        cyc(9000);
        check_bit("cpu_reset", 1'b1, cpu_reset);
        // Pin release below uses the long delay with a 1K count
        opts.rst_mode = MODES[2];
        opts.ext_reset_en = 1'b1;
        pull_rst = 1'b1;
        cyc(6);
        check_bit("cpu_reset", 1'b1, cpu_reset);
        pull_rst = 1'b0;
        wait_rel(n);
        check_in("release cycles", n, LONG + 8176, LONG + 8232);
        opts.ext_reset_en = 1'b0;
        pull_rst = 1'b1;
        cyc(6);
        check_bit("cpu_reset", 1'b0, cpu_reset);
        opts.ext_reset_en = 1'b1;
        running = 1'b0;
        cyc(6);
        check_bit("cpu_reset", 1'b0, cpu_reset);
        pull_rst = 1'b0;
        $display("test reset done");
    endtask

    // Watchdog: the tests need about 45000 cycles
    initial begin
        #1800000;
        error_cnt++;
        $display("unexpected run_time: expected finish, seen timeout");
        conclude();
    end

    initial begin
        nrst = 1'b0;
        opts = '{mask_int_step: 1'b0, step_timer: 1'b0, ext_reset_en: 1'b0, xram_en: 1'b1,
                 pod_clk_sel: 1'b1, pod_div: DIV_MIN, rst_mode: 4'hf};
        map_cmd = '0;
        {has_xbus, host_reset, running, stepping, step_pulse} = 5'b10100;
        {irq_req, data_wr, pull_rst} = 3'b000;
        data_addr = '0;
        cyc(12);
        nrst = 1'b1;
        cyc(4);
        t_map();
        t_we();
        t_irq_timer();
        t_clock();
        t_reset();
        conclude();
    end
endmodule
